// >>> src/prx_pkg.sv
// constants for the proximity result and modulator register slice
package prx_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_RESULT_HIGH   = 8'h87;
   localparam logic [7:0] ADR_RESULT_LOW    = 8'h88;
   localparam logic [7:0] ADR_FREQ_SELECT   = 8'h89;
   localparam logic [7:0] ADR_MOD_TIMING    = 8'h8A;
   localparam logic [7:0] READ_UNMAPPED     = 8'h00;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int         FREQ_LSB          = 0;
   localparam int         FREQ_W            = 2;
   localparam int         DELAY_LSB         = 5;
   localparam int         DELAY_W           = 3;
   localparam int         DEAD_LSB          = 0;
   localparam int         DEAD_W            = 3;
   localparam logic [1:0] FREQ_RESET        = 2'h2;
   localparam logic [2:0] DELAY_RESET       = 3'h0;
   localparam logic [2:0] DEAD_RESET        = 3'h0;

   // ------------------------------------------------------------
   // test signal synthesis: phase accumulator at 40 MHz
   // f = CLK_HZ * inc / 2**ACC_W; inc 40 gives 3.125 MHz, halved per code step
   // ------------------------------------------------------------
   localparam int         CLK_HZ            = 40_000_000;
   localparam int         ACC_W             = 9;
   localparam int         FREQ_TOP_HZ       = 3_125_000;
   localparam logic [8:0] ACC_INC_TOP       = 9'(FREQ_TOP_HZ / (CLK_HZ >> ACC_W));
   // delay and dead time are counted in core clock cycles (25 ns each)
   localparam int         HIST_DEPTH        = 8;
endpackage

// >>> src/prx_mod_if.sv
// carrier between the test signal source and the evaluation timing module
`timescale 1ns/1ps
interface prx_mod_if;
   logic       ir_drive;
   logic [2:0] delay_sel;
   logic [2:0] dead_sel;
   logic       eval_phase;
   logic       eval_en;
   modport src (output ir_drive, output delay_sel, output dead_sel,
                input eval_phase, input eval_en);
   modport tim (input ir_drive, input delay_sel, input dead_sel,
                output eval_phase, output eval_en);
endinterface

// >>> src/prx_mod_timing.sv
// delayed evaluation phase and dead-time blanking around its edges
`timescale 1ns/1ps
module prx_mod_timing (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   prx_mod_if.tim    mif
);
   typedef struct packed {
      logic [prx_pkg::HIST_DEPTH-1:0] hist;
      logic                           phase;
      logic [2:0]                     dead_cnt;
      logic                           en;
   } prx_tim_st_t;

   prx_tim_st_t s_r;
   prx_tim_st_t s_nxt;
   logic        dly_bit;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.hist = {s_r.hist[prx_pkg::HIST_DEPTH-2:0], mif.ir_drive};
      dly_bit  = s_r.hist[mif.delay_sel];
      s_nxt.phase = dly_bit;
      if (dly_bit != s_r.phase) begin
         // every slope restarts the blanking interval
         s_nxt.dead_cnt = mif.dead_sel;
         s_nxt.en       = 1'b0;
      end else if (s_r.dead_cnt != 3'h0) begin
         s_nxt.dead_cnt = s_r.dead_cnt - 3'h1;
         s_nxt.en       = 1'b0;
      end else begin
         s_nxt.en       = 1'b1;
      end
      // zero dead time never blanks once the counter is empty, even on the slope cycle
      if (mif.dead_sel == 3'h0 && s_r.dead_cnt == 3'h0) begin
         s_nxt.en = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mif.eval_phase = s_r.phase;
   assign mif.eval_en    = s_r.en;

   property p_dead_blank;
      @(posedge core_clk_i) disable iff (rst_i)
      (dly_bit != s_r.phase && mif.dead_sel != 3'h0) |=> !s_r.en;
   endproperty
   a_dead_blank: assert property (p_dead_blank)
      else $error("evaluation not blanked after slope");

   property p_delay_tap;
      @(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> s_r.phase == $past(s_r.hist[mif.delay_sel]);
   endproperty
   a_delay_tap: assert property (p_delay_tap)
      else $error("evaluation phase not taken from delay tap");
endmodule

// >>> src/prx_result_mod.sv
// proximity result registers, test signal frequency and modulator timing
// ------------------------------------------------------------
// Operation
// - result is 16 bits: high byte at 87h, low byte at 88h
// - 87h reads result bits 15:8, read only, writes ignored
// - 88h reads result bits 7:0, read only, writes ignored
// - 89h bits 1:0 pick test frequency 3.125M/1.5625M/781.25k/390.625k; rest unused
// - frequency code resets to 2, i.e. 781.25 kHz
// - emitter driven by a square wave at the selected frequency
// - 8Ah bits 7:5 delay evaluation of the returned signal
// - 8Ah bits 2:0 blank evaluation around signal slopes; bits 4:3 unused
// - register pointer advances by one after each byte read
// ------------------------------------------------------------
`timescale 1ns/1ps
module prx_result_mod (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ptr_load_i,
   input  wire logic [7:0]  ptr_addr_i,
   input  wire logic        wr_stb_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        rd_stb_i,
   output logic      [7:0]  rd_data_o,
   input  wire logic        meas_done_i,
   input  wire logic [15:0] meas_result_i,
   output logic             ir_drive_o,
   output logic             eval_phase_o,
   output logic             eval_en_o
);
   typedef struct packed {
      logic [7:0]  ptr;
      logic [7:0]  rd_data;
      logic [15:0] result;
      logic [7:0]  low_hold;
      logic        hold_vld;
      logic [1:0]  freq;
      logic [2:0]  delay;
      logic [2:0]  dead;
      logic [8:0]  acc;
      logic        ir;
      logic        phase;
      logic        en;
   } prx_st_t;

   prx_st_t    s_r;
   prx_st_t    s_nxt;
   logic [8:0] acc_inc;
   prx_mod_if  mif ();

   // ------------------------------------------------------------
   // register access and test signal
   // ------------------------------------------------------------
   always_comb begin
      s_nxt   = s_r;
      acc_inc = prx_pkg::ACC_INC_TOP >> s_r.freq;
      // a fractional accumulator is needed: 40 MHz is no integer multiple
      // of the 3.125 MHz test tone, so single periods jitter by one cycle
      s_nxt.acc = s_r.acc + acc_inc;
      s_nxt.ir  = s_r.acc[prx_pkg::ACC_W-1];
      s_nxt.phase = mif.eval_phase;
      s_nxt.en    = mif.eval_en;
      if (meas_done_i) begin
         s_nxt.result = meas_result_i;
      end
      if (ptr_load_i) begin
         s_nxt.ptr = ptr_addr_i;
      end else if (wr_stb_i) begin
         case (s_r.ptr)
            prx_pkg::ADR_FREQ_SELECT: begin
               s_nxt.freq = wr_data_i[prx_pkg::FREQ_LSB +: prx_pkg::FREQ_W];
            end
            prx_pkg::ADR_MOD_TIMING: begin
               s_nxt.delay = wr_data_i[prx_pkg::DELAY_LSB +: prx_pkg::DELAY_W];
               s_nxt.dead  = wr_data_i[prx_pkg::DEAD_LSB +: prx_pkg::DEAD_W];
            end
            default: begin
               // result bytes and unmapped addresses ignore writes
            end
         endcase
         s_nxt.ptr = s_r.ptr + 8'h01;
      end else if (rd_stb_i) begin
         case (s_r.ptr)
            prx_pkg::ADR_RESULT_HIGH: begin
               s_nxt.rd_data  = s_r.result[15:8];
               // freeze the low byte so a later update cannot split the pair
               s_nxt.low_hold = s_r.result[7:0];
               s_nxt.hold_vld = 1'b1;
            end
            prx_pkg::ADR_RESULT_LOW: begin
               s_nxt.rd_data  = s_r.hold_vld ? s_r.low_hold : s_r.result[7:0];
               s_nxt.hold_vld = 1'b0;
            end
            prx_pkg::ADR_FREQ_SELECT: begin
               s_nxt.rd_data = {6'h00, s_r.freq};
            end
            prx_pkg::ADR_MOD_TIMING: begin
               s_nxt.rd_data = {s_r.delay, 2'h0, s_r.dead};
            end
            default: begin
               s_nxt.rd_data = prx_pkg::READ_UNMAPPED;
            end
         endcase
         s_nxt.ptr = s_r.ptr + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r       <= '0;
         s_r.freq  <= prx_pkg::FREQ_RESET;
         s_r.delay <= prx_pkg::DELAY_RESET;
         s_r.dead  <= prx_pkg::DEAD_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // evaluation timing
   // ------------------------------------------------------------
   assign mif.ir_drive  = s_r.ir;
   assign mif.delay_sel = s_r.delay;
   assign mif.dead_sel  = s_r.dead;

   prx_mod_timing u_tim (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .mif        (mif.tim)
   );

   assign rd_data_o    = s_r.rd_data;
   assign ir_drive_o   = s_r.ir;
   assign eval_phase_o = s_r.phase;
   assign eval_en_o    = s_r.en;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_rd_at(logic [7:0] a);
      rd_stb_i && !ptr_load_i && !wr_stb_i && s_r.ptr == a;
   endsequence

   property p_map_high;
      @(posedge core_clk_i) disable iff (rst_i)
      s_rd_at(prx_pkg::ADR_RESULT_HIGH) |=> rd_data_o == $past(s_r.result[15:8]);
   endproperty
   a_map_high: assert property (p_map_high)
      else $error("high result byte not returned at its address");

   property p_ro_high;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_stb_i && !ptr_load_i && !meas_done_i && s_r.ptr == prx_pkg::ADR_RESULT_HIGH)
         |=> $stable(s_r.result);
   endproperty
   a_ro_high: assert property (p_ro_high)
      else $error("write altered result");

   property p_ro_low;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_stb_i && !ptr_load_i && !meas_done_i && s_r.ptr == prx_pkg::ADR_RESULT_LOW)
         |=> $stable(s_r.result);
   endproperty
   a_ro_low: assert property (p_ro_low)
      else $error("write to low byte altered result");

   property p_pair;
      @(posedge core_clk_i) disable iff (rst_i)
      s_rd_at(prx_pkg::ADR_RESULT_HIGH) ##1 s_rd_at(prx_pkg::ADR_RESULT_LOW)
         |=> rd_data_o == $past(s_r.result[7:0], 2);
   endproperty
   a_pair: assert property (p_pair)
      else $error("low byte from other measurement than high byte");

   property p_freq;
      @(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> s_r.acc == 9'($past(s_r.acc) + (prx_pkg::ACC_INC_TOP >> $past(s_r.freq)));
   endproperty
   a_freq: assert property (p_freq)
      else $error("accumulator step does not match frequency code");

   property p_freq_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      s_rd_at(prx_pkg::ADR_FREQ_SELECT) |=> rd_data_o == {6'h00, $past(s_r.freq)};
   endproperty
   a_freq_rd: assert property (p_freq_rd)
      else $error("frequency code not read back in bits 1:0");

   property p_timing_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      s_rd_at(prx_pkg::ADR_MOD_TIMING)
         |=> rd_data_o == {$past(s_r.delay), 2'h0, $past(s_r.dead)};
   endproperty
   a_timing_rd: assert property (p_timing_rd)
      else $error("timing fields not read back in place");

   property p_freq_reset;
      @(posedge core_clk_i) $past(rst_i) && !rst_i |-> s_r.freq == prx_pkg::FREQ_RESET;
   endproperty
   a_freq_reset: assert property (p_freq_reset)
      else $error("frequency code not at reset value");

   property p_drive;
      @(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> ir_drive_o == $past(s_r.acc[prx_pkg::ACC_W-1]);
   endproperty
   a_drive: assert property (p_drive)
      else $error("emitter drive not the accumulator msb");

   property p_timing_wr;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_stb_i && !ptr_load_i && s_r.ptr == prx_pkg::ADR_MOD_TIMING)
         |=> s_r.delay == $past(wr_data_i[7:5]) && s_r.dead == $past(wr_data_i[2:0]);
   endproperty
   a_timing_wr: assert property (p_timing_wr)
      else $error("timing register write lost");

   property p_ptr_inc;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_stb_i && !ptr_load_i && !wr_stb_i) |=> s_r.ptr == 8'($past(s_r.ptr) + 8'h01);
   endproperty
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("pointer did not advance after read");

   property p_capture;
      @(posedge core_clk_i) disable iff (rst_i)
      meas_done_i |=> s_r.result == $past(meas_result_i);
   endproperty
   a_capture: assert property (p_capture)
      else $error("measurement not captured whole");
endmodule

// >>> verification/prx_host.sv
// host side model driving the register pointer, write and read strobes
`timescale 1ns/1ps
module prx_host (
   input  wire logic       core_clk_i,
   output logic            ptr_load_o,
   output logic      [7:0] ptr_addr_o,
   output logic            wr_stb_o,
   output logic      [7:0] wr_data_o,
   output logic            rd_stb_o,
   input  wire logic [7:0] rd_data_i
);
   initial begin
      {ptr_load_o, wr_stb_o, rd_stb_o} = 3'h0;
      ptr_addr_o = 8'h00;
      wr_data_o = 8'h00;
   end
   // ------------------------------------------------------------
   // bus steps
   // ------------------------------------------------------------
   // k = {load, write, read}; entered at a falling edge, leaves at the next
   task automatic op(input logic [2:0] k, input logic [7:0] v, output logic [7:0] d);
      {ptr_load_o, wr_stb_o, rd_stb_o} = k;
      ptr_addr_o = v;
      wr_data_o = v;
      @(negedge core_clk_i);
      d = rd_data_i;
   endtask
   task automatic put(input logic [7:0] adr, input logic [7:0] v);
      logic [7:0] d;
      op(3'h4, adr, d);
      op(3'h2, v, d);
      op(3'h0, v, d);
   endtask
   task automatic get(input logic [7:0] adr, output logic [7:0] d);
      logic [7:0] x;
      op(3'h4, adr, x);
      op(3'h1, adr, d);
      op(3'h0, adr, x);
   endtask
   // delay 4, dead 1: the smallest nonzero dead time, it costs signal level
   task automatic tune();
      put(8'h8A, 8'h81);
   endtask
endmodule

// >>> verification/prx_result_mod_tb.sv
// self-checking bench for the proximity result and modulator registers
`timescale 1ns/1ps
module prx_result_mod_tb;
   logic        core_clk_i    = 1'b0;
   logic        rst_i         = 1'b1;
   logic        meas_done_i   = 1'b0;
   logic [15:0] meas_result_i = 16'h0000;
   logic        ptr_load, wr_stb, rd_stb, ir_drive, eval_phase, eval_en;
   logic [7:0]  ptr_addr, wr_data, rd_data, q, h, l;
   int          errors        = 0;
   int          compares      = 0;
   int          a, b, c, e;

   always #12.5 core_clk_i = ~core_clk_i;

   prx_host i_prx_host (.core_clk_i(core_clk_i), .ptr_load_o(ptr_load),
      .ptr_addr_o(ptr_addr), .wr_stb_o(wr_stb), .wr_data_o(wr_data),
      .rd_stb_o(rd_stb), .rd_data_i(rd_data));
   prx_result_mod i_prx_result_mod (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .ptr_load_i(ptr_load), .ptr_addr_i(ptr_addr), .wr_stb_i(wr_stb),
      .wr_data_i(wr_data), .rd_stb_i(rd_stb), .rd_data_o(rd_data),
      .meas_done_i(meas_done_i), .meas_result_i(meas_result_i),
      .ir_drive_o(ir_drive), .eval_phase_o(eval_phase), .eval_en_o(eval_en));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic meas(input logic [15:0] v);
      meas_done_i = 1'b1;
      meas_result_i = v;
      @(negedge core_clk_i);
      meas_done_i = 1'b0;
   endtask
   // cycles from a drive rise to the following evaluation phase rise
   task automatic lag(output int n);
      n = 0;
      h[0] = 1'b1;
      while (!(ir_drive === 1'b1 && h[0] === 1'b0) && n < 200) begin
         h[0] = ir_drive;
         @(negedge core_clk_i);
         n++;
      end
      n = 0;
      while (eval_phase !== 1'b1 && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
   endtask
   // settle first so blanking left from an older dead time is not counted
   task automatic lows(output int n);
      n = 0;
      repeat (16) @(negedge core_clk_i);
      repeat (512) begin
         @(negedge core_clk_i);
         if (eval_en !== 1'b1) n++;
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      i_prx_host.get(8'h89, q);
      chk(q, 8'h02);
      i_prx_host.get(8'h8A, q);
      chk(q, 8'h00);
      i_prx_host.get(8'h8B, q);
      chk(q, prx_pkg::READ_UNMAPPED);
      i_prx_host.put(8'h89, 8'hFF);
      i_prx_host.get(8'h89, q);
      chk(q, 8'h03);
   endtask
   task automatic t_freq();
      for (c = 0; c < 4; c++) begin
         i_prx_host.put(8'h89, 8'(c));
         i_prx_host.get(8'h89, q);
         chk(q, 8'(c));
         a = 0;
         e = 80 >> c;
         for (b = 0; b < 1024; b++) begin
            h[0] = ir_drive;
            @(negedge core_clk_i);
            if (ir_drive === 1'b1 && h[0] === 1'b0) a++;
         end
         chk(8'(a >= e - 1 && a <= e + 1), 8'h01);
      end
      i_prx_host.put(8'h89, 8'h02);
   endtask
   task automatic t_result();
      meas(16'hA5C3);
      i_prx_host.op(3'h4, 8'h87, q);
      i_prx_host.op(3'h1, 8'h87, h);
      i_prx_host.op(3'h0, 8'h87, q);
      meas(16'h5A3C);
      i_prx_host.op(3'h1, 8'h87, l);
      i_prx_host.op(3'h0, 8'h87, q);
      chk(h, 8'hA5);
      chk(l, 8'hC3);
      i_prx_host.put(8'h87, 8'hFF);
      i_prx_host.put(8'h88, 8'hFF);
      i_prx_host.op(3'h4, 8'h87, q);
      i_prx_host.op(3'h1, 8'h87, h);
      i_prx_host.op(3'h1, 8'h87, l);
      i_prx_host.op(3'h0, 8'h87, q);
      chk(h, 8'h5A);
      chk(l, 8'h3C);
      i_prx_host.get(8'h88, l);
      chk(l, 8'h3C);
   endtask
   task automatic t_timing();
      i_prx_host.tune();
      i_prx_host.get(8'h8A, q);
      chk(q, 8'h81);
      i_prx_host.put(8'h8A, 8'hFF);
      i_prx_host.get(8'h8A, q);
      chk(q, 8'hE7);
      i_prx_host.put(8'h8A, 8'h00);
      lows(a);
      chk(8'(a), 8'h00);
      lag(a);
      i_prx_host.put(8'h8A, 8'h80);
      lag(b);
      chk(8'(b - a), 8'h04);
      i_prx_host.put(8'h8A, 8'h01);
      lows(a);
      i_prx_host.put(8'h8A, 8'h03);
      lows(b);
      chk(8'(a > 0 && b > a), 8'h01);
   endtask

   // a reset in mid-run must bring the control fields back to their start values
   task automatic t_reset();
      i_prx_host.put(8'h89, 8'h03);
      i_prx_host.put(8'h8A, 8'hFF);
      rst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      i_prx_host.get(8'h89, q);
      chk(q, 8'h02);
      i_prx_host.get(8'h8A, q);
      chk(q, 8'h00);
   endtask

   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(negedge core_clk_i);
      rst_i = 1'b0;
      t_regs();
      t_freq();
      t_result();
      t_timing();
      t_reset();
      results();
   end
   // about three times the expected run
   initial begin
      #500000;
      errors++;
      results();
   end
endmodule
